// ### shared/kwu_regs.svh
// register map and fixed values of the key wakeup block
// included by the top block and the testbench; definitions only
`ifndef KWU_REGS_SVH
`define KWU_REGS_SVH
`define KWE_INDEX 12'hfaa
`define KWE_ADDR 14'h3ea8
`define CTRL_ADDR 14'h3eac
`define STAT_ADDR 14'h3eb0
`define KWE_EN_MSB 7
`define KWE_EN_LSB 4
`define KWE_RESET 4'h0
`define CTRL_RESET 2'h0
`define CTRL_RELM_BIT 0
`define CTRL_STOP_BIT 1
`define WARMUP_NS 1000
`endif

// ### shared/kwu_pkg.sv
// types shared by the key wakeup block
// no assumptions beyond a standard tool flow
package kwu_pkg;
  typedef enum logic [2:0] {
    st_run = 3'b001,
    st_stop = 3'b010,
    st_warm = 3'b100
  } stop_state_t;
endpackage

// ### core/wake_detect.sv
// wakeup source detector: key pins and primary wake pin
// pins are synchronous to core_clk_in
`timescale 1ns/1ps
module wake_detect #(
  parameter int KEYS = 4
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [KEYS-1:0] key_pin_in,
  input wire logic [KEYS-1:0] key_en_in,
  input wire logic stop_pin_in,
  input wire logic level_mode_in,
  output logic wake_out
);
  logic stop_pin_q;
  logic next_stop_pin_q;
  logic [KEYS-1:0] key_hit;
  logic key_any;
  logic prim_hit;

  initial begin
    if (KEYS < 1) begin
      $error("KEYS must be at least one");
    end
  end

  // per pin enable and inverted level
  genvar g;
  generate
    for (g = 0; g < KEYS; g++) begin : g_key
      assign key_hit[g] = key_en_in[g] & ~key_pin_in[g]; // [RULE13] [RULE4]
    end
  endgenerate

  always_comb begin
    next_stop_pin_q = stop_pin_in;
    key_any = |key_hit; // [RULE13]
    // level: high releases; edge: rising edge releases, keys unused
    if (level_mode_in) begin
      prim_hit = stop_pin_in; // [RULE5]
      wake_out = prim_hit | key_any; // [RULE5] [RULE13]
    end else begin
      prim_hit = stop_pin_in & ~stop_pin_q; // [RULE5]
      wake_out = prim_hit;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stop_pin_q <= 1'b0;
    end else begin
      stop_pin_q <= next_stop_pin_q;
    end
  end
endmodule

// ### core/key_wakeup_stop_release.sv
// key wakeup stop release with avalon-mm register slave
// assumes synchronous pins and a single 100 MHz clock
// Notes on behaviour
// RULE1 - one enable bit per key pin
// RULE2 - enables in bits 7..4, write only
// RULE3 - enables clear at reset
// RULE4 - enabled key pin low ends stop
// RULE5 - level mode keys low; edge mode primary only
// RULE6 - wake condition at entry skips stop
// RULE7 - primary wake pin stays in use
// RULE8 - primary pin held low for key release
// RULE9 - firmware checks key pins high first
// RULE10 - edge mode: keys disabled or high
// RULE11 - key pins configured as inputs
// RULE12 - enabled key pins not analog inputs
// RULE13 - key request is or of enable and not pin
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "kwu_regs.svh"
module key_wakeup_stop_release
  import kwu_pkg::*;
#(
  parameter int KEYS = 4,
  parameter int CLK_MHZ = 100
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [13:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [KEYS-1:0] key_wake_pin_in,
  input wire logic stop_pin_in,
  output logic stop_mode_out,
  output logic warmup_out
);
  localparam int WARM_CYC_RAW = (`WARMUP_NS * CLK_MHZ + 999) / 1000;
  localparam int WARM_CYC = (WARM_CYC_RAW < 1) ? 1 : WARM_CYC_RAW;
  localparam int CW = $clog2(WARM_CYC + 1);

  initial begin
    if (KEYS != (`KWE_EN_MSB - `KWE_EN_LSB + 1)) begin
      $error("KEYS must match the enable nibble");
    end
    if (CLK_MHZ < 1) begin
      $error("CLK_MHZ must be at least one");
    end
  end

  logic [KEYS-1:0] key_en;
  logic [KEYS-1:0] next_key_en;
  logic relm;
  logic next_relm;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic stop_req;
  logic wake;
  stop_state_t state;
  stop_state_t next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_stop_mode;
  logic next_warmup;
  logic next_waitreq;
  logic [CW-1:0] warm_len;
  logic [CW-1:0] next_warm_len;

  wake_detect #(.KEYS(KEYS)) u_detect (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .key_pin_in(key_wake_pin_in),
    .key_en_in(key_en),
    .stop_pin_in(stop_pin_in),
    .level_mode_in(relm),
    .wake_out(wake)
  );

  // bus slave: one wait cycle; a write lands with the answer
  always_comb begin
    next_key_en = key_en;
    next_relm = relm;
    next_ack = 1'b0;
    next_waitreq = 1'b1;
    next_rdata = 32'h0;
    stop_req = 1'b0;
    if ((avs_read_in | avs_write_in) & ~ack) begin
      next_ack = 1'b1;
      next_waitreq = 1'b0;
    end
    if (avs_write_in & ack & avs_byteenable_in[0]) begin
      unique case (avs_address_in)
        `KWE_ADDR: begin
          next_key_en = avs_writedata_in[`KWE_EN_MSB:`KWE_EN_LSB]; // [RULE1] [RULE2]
        end
        `CTRL_ADDR: begin
          next_relm = avs_writedata_in[`CTRL_RELM_BIT];
          stop_req = avs_writedata_in[`CTRL_STOP_BIT];
        end
        default: begin
        end
      endcase
    end
    if (avs_read_in & ~ack) begin
      unique case (avs_address_in)
        `KWE_ADDR: next_rdata = 32'h0; // [RULE2]
        `CTRL_ADDR: next_rdata = {31'h0, relm};
        `STAT_ADDR: next_rdata = {29'h0, warmup_out, stop_mode_out, wake};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      key_en <= `KWE_RESET; // [RULE3]
      relm <= 1'b0;
      ack <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      rdata <= 32'h0;
    end else begin
      key_en <= next_key_en;
      relm <= next_relm;
      ack <= next_ack;
      avs_waitrequest_out <= next_waitreq;
      rdata <= next_rdata;
    end
  end

  always_comb begin
    avs_readdata_out = rdata;
  end

  // stop sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      st_run: begin
        if (stop_req) begin
          next_cnt = CW'(WARM_CYC);
          next_state = wake ? st_warm : st_stop; // [RULE6]
        end
      end
      st_stop: begin
        if (wake) begin
          next_cnt = CW'(WARM_CYC);
          next_state = st_warm; // [RULE4] [RULE5]
        end
      end
      st_warm: begin
        next_cnt = cnt - CW'(1);
        if (cnt == CW'(1)) begin
          next_state = st_run;
        end
      end
      default: next_state = st_run;
    endcase
    next_stop_mode = (next_state == st_stop);
    next_warmup = (next_state == st_warm);
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= st_run;
      cnt <= '0;
      stop_mode_out <= 1'b0;
      warmup_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      stop_mode_out <= next_stop_mode;
      warmup_out <= next_warmup;
    end
  end

  chk_key_release_wake: assert property ( // [RULE4]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (state == st_stop && relm && |(key_en & ~key_wake_pin_in))
    |=> warmup_out && !stop_mode_out)
    else $error("enabled low key pin did not end stop");

  chk_entry_skip_stop: assert property ( // [RULE6]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (state == st_run && stop_req && relm && stop_pin_in)
    |=> !stop_mode_out && warmup_out)
    else $error("stop entered despite active wake");

  chk_edge_keys_ignored: assert property ( // [RULE5]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (state == st_stop && !relm && !stop_pin_in) |=> stop_mode_out)
    else $error("edge mode left stop without a rising edge");

  chk_enable_reset: assert property ( // [RULE3]
    @(posedge core_clk_in) $rose(rst_b_in) |-> key_en == `KWE_RESET)
    else $error("key enables not cleared by reset");

  chk_enable_write: assert property ( // [RULE1]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (avs_write_in && ack && avs_byteenable_in[0]
     && avs_address_in == `KWE_ADDR)
    |=> key_en == $past(avs_writedata_in[`KWE_EN_MSB:`KWE_EN_LSB]))
    else $error("enable bits not stored from bits 7..4");

  chk_enable_write_only: assert property ( // [RULE2]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (avs_read_in && !ack && avs_address_in == `KWE_ADDR)
    |=> rdata == 32'h0)
    else $error("write-only enable register read back");

  chk_warm_length: assert property ( // [RULE6]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    $rose(warmup_out) |-> warmup_out [*8] ##[0:300] !warmup_out)
    else $error("warm-up length wrong");

  chk_disabled_key_quiet: assert property ( // [RULE13]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (state == st_stop && !stop_pin_in && !(|key_en)) |=> stop_mode_out)
    else $error("disabled key pins released stop");

  // helper: cycles spent in warm-up so far
  always_comb begin
    next_warm_len = '0;
    if (warmup_out) begin
      next_warm_len = warm_len + CW'(1);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      warm_len <= '0;
    end else begin
      warm_len <= next_warm_len;
    end
  end

  sequence seq_warm_begins;
    warmup_out && !stop_mode_out;
  endsequence

  sequence seq_stays_stopped;
    stop_mode_out && !warmup_out;
  endsequence

  sequence seq_bus_taken;
    (avs_read_in || avs_write_in) && !ack;
  endsequence

  chk_warm_exact: assert property ( // [RULE6]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    $fell(warmup_out) |-> warm_len == CW'(WARM_CYC))
    else $error("warm-up did not last the set cycle count");

  chk_level_primary: assert property ( // [RULE5]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (state == st_stop && relm && stop_pin_in) |=> seq_warm_begins)
    else $error("high primary pin did not end stop in level mode");

  chk_edge_primary: assert property ( // [RULE5]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (state == st_stop && !relm && stop_pin_in && !$past(stop_pin_in))
    |=> seq_warm_begins)
    else $error("rising primary pin did not end stop in edge mode");

  chk_stop_entry: assert property ( // [RULE6]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (state == st_run && stop_req && !wake) |=> seq_stays_stopped)
    else $error("stop not entered with no wake source");

  chk_bus_answer: assert property ( // [RULE2]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    seq_bus_taken |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer not one cycle after the request");

  chk_enable_hold: assert property ( // [RULE1]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    !(avs_write_in && ack && avs_address_in == `KWE_ADDR)
    |=> $stable(key_en))
    else $error("key enables changed without a write");

  chk_one_status: assert property ( // [RULE4]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    !(stop_mode_out && warmup_out))
    else $error("stop and warm-up flags both set");

  chk_unmapped_read: assert property ( // [RULE2]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (avs_read_in && !ack && avs_address_in != `KWE_ADDR
     && avs_address_in != `CTRL_ADDR && avs_address_in != `STAT_ADDR)
    |=> rdata == 32'h0)
    else $error("unmapped address read nonzero");

  chk_ctrl_readback: assert property ( // [RULE5]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (avs_read_in && !ack && avs_address_in == `CTRL_ADDR)
    |=> rdata[`CTRL_RELM_BIT] == $past(relm))
    else $error("release mode select not read back");

  chk_reset_idle: assert property ( // [RULE3]
    @(posedge core_clk_in)
    $rose(rst_b_in)
    |-> avs_waitrequest_out && !stop_mode_out && !warmup_out)
    else $error("outputs not idle after reset");

  chk_warm_to_run: assert property ( // [RULE6]
    @(posedge core_clk_in) disable iff (!rst_b_in)
    $fell(warmup_out) |-> state == st_run && !stop_mode_out)
    else $error("warm-up did not return to run");
endmodule

// ### sim/key_switches.sv
// keys and primary wake pin outside the block
// assumes pins sampled on the core clock
`timescale 1ns/1ps
module key_switches (
  input wire logic [3:0] press_in,
  input wire logic stop_level_in,
  output logic [3:0] key_wake_pin_out,
  output logic stop_pin_out
);
  // pressed key pulls its pin low, digital levels only
  assign key_wake_pin_out = ~press_in;
  // primary pin stays wired, low unless driven high
  assign stop_pin_out = stop_level_in;
endmodule

// ### sim/key_wakeup_stop_release_tb.sv
// self-checking bench for the key wakeup block
// assumes the key model and the register map header
`timescale 1ns/1ps
`include "kwu_regs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  n_mismatch++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module key_wakeup_stop_release_tb;
  logic core_clk_in = 0;
  logic rst_b_in = 0;
  logic [13:0] adr = 0;
  logic rd_en = 0;
  logic wr_en = 0;
  logic [31:0] wdat = 0;
  logic [31:0] rdat;
  logic wait_req;
  logic stop_pin;
  logic stop_o;
  logic warm_o;
  logic stop_lvl = 0;
  logic [3:0] pins;
  logic [3:0] press = 0;
  logic [31:0] q[$];
  logic [31:0] exp_v;
  int n_mismatch = 0;
  int total_checks = 0;
  int seed = 15;
  int j;
  initial forever #5 core_clk_in = ~core_clk_in;
  key_wakeup_stop_release key_wakeup_stop_release_inst (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .avs_address_in(adr), .avs_read_in(rd_en), .avs_write_in(wr_en),
    .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_req),
    .key_wake_pin_in(pins), .stop_pin_in(stop_pin),
    .stop_mode_out(stop_o), .warmup_out(warm_o));
  key_switches key_switches_inst (.press_in(press), .stop_level_in(stop_lvl),
    .key_wake_pin_out(pins), .stop_pin_out(stop_pin));
  // read answers against the oldest note
  always @(posedge core_clk_in)
    if (rd_en && wait_req === 1'b0 && q.size() > 0) begin
      exp_v = q.pop_front();
      `CHK(rdat, exp_v)
      if (adr == `STAT_ADDR)
        `CHK({warm_o, stop_o}, exp_v[2:1])
    end
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [13:0] a,
                     input logic [31:0] d);
    adr <= a;
    wdat <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge core_clk_in);
    while (wait_req !== 1'b0)
      @(posedge core_clk_in);
    wr_en <= 0;
    rd_en <= 0;
    @(posedge core_clk_in);
  endtask
  task automatic rd(input logic [13:0] a, input logic [31:0] e);
    q.push_back(e);
    acc(0, a, 0);
  endtask
  task automatic pulse(input logic [3:0] m, input logic s);
    press <= m;
    stop_lvl <= s;
    repeat (3) @(posedge core_clk_in);
    press <= 0;
    stop_lvl <= 0;
    @(posedge core_clk_in);
  endtask
  task automatic rst;
    rst_b_in <= 0;
    repeat (20) @(posedge core_clk_in);
    rst_b_in <= 1;
    @(posedge core_clk_in);
  endtask
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  initial begin
    rst();
    rd(`KWE_ADDR, 0);
    rd(`STAT_ADDR, 0);
    rd(`STAT_ADDR + 14'h4, 0);
    acc(1, `CTRL_ADDR, 3);
    rd(`CTRL_ADDR, 1);
    pulse(4'hf, 0);
    rd(`STAT_ADDR, 2);
    pulse(0, 1);
    rd(`STAT_ADDR, 4);
    repeat (110) @(posedge core_clk_in);
    for (int k = 0; k < 4; k++) begin
      j = (k + 1 + {$random(seed)} % 3) % 4;
      acc(1, `KWE_ADDR, 32'h10 << k);
      acc(1, `CTRL_ADDR, 3); // keys all high at entry
      pulse(4'h1 << j, 0);
      rd(`STAT_ADDR, 2);
      pulse(4'h1 << k, 0);
      rd(`STAT_ADDR, 4);
      repeat (110) @(posedge core_clk_in);
    end
    acc(1, `KWE_ADDR, 32'hf0);
    press <= 4'h2;
    acc(1, `CTRL_ADDR, 3);
    rd(`STAT_ADDR, 5);
    press <= 0;
    repeat (110) @(posedge core_clk_in);
    acc(1, `KWE_ADDR, 0); // keys off in edge mode
    acc(1, `CTRL_ADDR, 2);
    pulse(4'hf, 0);
    rd(`STAT_ADDR, 2);
    pulse(0, 1);
    rd(`STAT_ADDR, 4);
    repeat (110) @(posedge core_clk_in);
    acc(1, `KWE_ADDR, 32'hf0);
    rst();
    acc(1, `CTRL_ADDR, 3);
    pulse(4'hf, 0);
    rd(`STAT_ADDR, 2);
    results();
  end
endmodule
